// ---- tuning_pkg.sv ----
// tuning_pkg: constants, types and register map for the tuning counter block
// assumes a single 20 MHz core clock and an AXI4-Lite register bus
`default_nettype none
package tuning_pkg;
   localparam int CLK_HZ = 20000000;
   // one-shot lengths in microseconds, converted to cycles below
   localparam int READ_PULSE_US = 50;
   localparam int WRITE_PULSE_US = 100;
   localparam int READ_PULSE_CYC = (READ_PULSE_US * (CLK_HZ / 1000000) < 1) ? 1 : READ_PULSE_US * (CLK_HZ / 1000000);
   localparam int WRITE_PULSE_CYC = (WRITE_PULSE_US * (CLK_HZ / 1000000) < 1) ? 1 : WRITE_PULSE_US * (CLK_HZ / 1000000);
   localparam int PRESCALE_MOD = 10;
   localparam int NUM_CHANNELS = 12;
   localparam int NUM_DIGITS = 7;
   localparam int TOP_DIGIT_MAX = 2;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] FREQ_OFS = 8'h08;
   // control field positions
   localparam int CTRL_RATE_POS = 0;
   localparam int CTRL_DISP_OPT_POS = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // status field positions
   localparam int ST_READ_POS = 0;
   localparam int ST_WRITE_POS = 1;
   localparam int ST_BLANK_POS = 2;
   localparam int ST_GATE_POS = 3;
   localparam int ST_CHAN_POS = 4;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {RATE_SLOW = 2'b00, RATE_MEDIUM = 2'b01, RATE_FAST = 2'b10} rate_t;
   typedef enum logic [1:0] {MEM_IDLE = 2'b00, MEM_WRITE = 2'b01, MEM_CHECK = 2'b11} mem_state_t;
   typedef logic [3:0] digit_t;
   // channel address as produced by the switch decoder
   typedef struct packed {
      logic chan_addr_bit1;
      logic chan_addr_bit0;
      logic [1:0] row;
   } chan_sel_t;
   // encoder-side pulse stream, asynchronous; synchronised to core_clk inside the block
   typedef struct packed {
      logic tuneClk;
      logic doubledClk;
      logic upDir;
   } tune_in_t;
endpackage : tuning_pkg
`default_nettype wire

// ---- tuning_counter_channel_memory.sv ----
// tuning_counter_channel_memory: decade up/down frequency counter with 12-channel store
// assumes encoder pulses, switches and power-good arrive asynchronously and are synchronised here
//
// Overview of operation
// R01: tune clocks step decade counters, up or down
// R02: medium rate uses doubled pulse stream
// R03: gate clocks: tune mode or clarifier low
// R04: slow rate enables first stage every tenth
// R05: medium and fast keep first enable on
// R06: fast forces low digits zero, 1 kHz steps
// R07: top digit wraps within zero to two
// R08: counters feed memory, memory feeds presets
// R09: two address lines plus row select, 12 channels
// R10: channel change makes stretched read pulse
// R11: read pulse loads stored frequency into counters
// R12: write pulse stores counters into selected channel
// R13: load key fires write, then check read
// R14: option one blanks display in channel mode
// R15: rate wiper grounded only while power good
// R16: read pulse blocks tuning clocks
`default_nettype none
module tuning_counter_channel_memory #(
   parameter int READ_CYC = tuning_pkg::READ_PULSE_CYC,
   parameter int WRITE_CYC = tuning_pkg::WRITE_PULSE_CYC
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire tuning_pkg::tune_in_t tuneIn,
   input wire tuning_pkg::chan_sel_t chanSel,
   input wire logic tuneMode,
   input wire logic loadKey,
   input wire logic clarLimit,
   input wire logic powerGood,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [27:0] freqOut,
   output logic displayBlank,
   output logic wiperGround,
   output logic parallelLoadOut
);
   import tuning_pkg::*;

   // two-stage synchronisers for every off-chip level
   logic [8:0] syncA_reg;
   logic [8:0] syncB_reg;
   always_ff @(posedge core_clk) begin
      syncA_reg <= {tuneIn, chanSel, tuneMode, loadKey};
      syncB_reg <= syncA_reg;
   end
   logic sClarA_reg, sClar_reg, sPgA_reg, sPg_reg;
   always_ff @(posedge core_clk) begin
      sClarA_reg <= clarLimit;
      sClar_reg <= sClarA_reg;
      sPgA_reg <= powerGood;
      sPg_reg <= sPgA_reg;
   end
   logic sTuneClk, sDblClk, sUp, sTune, sLoad;
   chan_sel_t sChan;
   assign {sTuneClk, sDblClk, sUp} = syncB_reg[8:6];
   assign sChan = chan_sel_t'(syncB_reg[5:2]);
   assign sTune = syncB_reg[1];
   assign sLoad = syncB_reg[0];

   // control register from software
   logic [31:0] ctrl_reg;
   rate_t rate;
   logic dispOption2;
   assign rate = rate_t'(ctrl_reg[CTRL_RATE_POS +: 2]);
   assign dispOption2 = ctrl_reg[CTRL_DISP_OPT_POS];

   // rising edges of the chosen clock stream
   logic tuneClkPrev_reg, dblClkPrev_reg;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tuneClkPrev_reg <= 1'b0;
         dblClkPrev_reg <= 1'b0;
      end else begin
         tuneClkPrev_reg <= sTuneClk;
         dblClkPrev_reg <= sDblClk;
      end
   end
   logic rawStep;
   assign rawStep = (rate == RATE_MEDIUM) ? (sDblClk & ~dblClkPrev_reg) // [R02]
                                          : (sTuneClk & ~tuneClkPrev_reg);

   // clock gate plus read priority
   logic readActive;
   logic tuneClockGate;
   assign tuneClockGate = rawStep & (sTune | ~sClar_reg) & ~readActive; // [R03] [R16]

   // divide-by-ten prescaler on gated clocks
   logic [3:0] prescale_reg;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prescale_reg <= 4'h0;
      end else if (tuneClockGate) begin
         if (sUp) prescale_reg <= (prescale_reg == 4'(PRESCALE_MOD - 1)) ? 4'h0 : prescale_reg + 4'h1;
         else prescale_reg <= (prescale_reg == 4'h0) ? 4'(PRESCALE_MOD - 1) : prescale_reg - 4'h1;
      end
   end
   logic stageCountEnable_n, firstStageEnableGate;
   // slow passes one step in ten; other rates always enabled
   assign stageCountEnable_n = ~(sUp ? (prescale_reg == 4'(PRESCALE_MOD - 1)) : (prescale_reg == 4'h0));
   assign firstStageEnableGate = (rate != RATE_SLOW) | ~stageCountEnable_n; // [R04] [R05]

   // channel memory array, one 28-bit BCD word per channel
   logic [27:0] chanMem [0:NUM_CHANNELS-1];
   function automatic logic [3:0] chanIndex(input chan_sel_t c);
      logic [3:0] idx;
      idx = {c.row, c.chan_addr_bit1, c.chan_addr_bit0}; // [R09]
      return (idx >= 4'(NUM_CHANNELS)) ? 4'h0 : idx;
   endfunction : chanIndex

   // BCD digit step with carry; top digit limit passed in
   function automatic logic [4:0] digitStep(input digit_t d, input logic up, input digit_t maxV);
      if (up) return (d >= maxV) ? {1'b1, 4'h0} : {1'b0, d + 4'h1};
      else return (d == 4'h0) ? {1'b1, maxV} : {1'b0, d - 4'h1};
   endfunction : digitStep

   // read / write one-shot sequencer
   mem_state_t memState_reg;
   logic [15:0] shotCnt_reg;
   logic [3:0] chanPrev_reg;
   logic loadPrev_reg;
   logic readPulse_reg;
   logic [15:0] readCnt_reg;
   logic chanChange, loadPress;
   assign chanChange = (chanIndex(sChan) != chanPrev_reg);
   assign loadPress = sLoad & ~loadPrev_reg;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         chanPrev_reg <= 4'h0;
         loadPrev_reg <= 1'b0;
      end else begin
         chanPrev_reg <= chanIndex(sChan);
         loadPrev_reg <= sLoad;
      end
   end
   // write one-shot, then check read at its end
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         memState_reg <= MEM_IDLE;
         shotCnt_reg <= 16'h0000;
      end else begin
         case (memState_reg)
            MEM_IDLE: if (loadPress) begin // [R13]
               memState_reg <= MEM_WRITE;
               shotCnt_reg <= 16'(WRITE_CYC - 1);
            end
            MEM_WRITE: if (shotCnt_reg == 16'h0000) memState_reg <= MEM_CHECK;
               else shotCnt_reg <= shotCnt_reg - 16'h0001;
            MEM_CHECK: memState_reg <= MEM_IDLE;
            default: memState_reg <= MEM_IDLE;
         endcase
      end
   end
   logic writePulse;
   assign writePulse = (memState_reg == MEM_WRITE);
   // read pulse stretched from a channel edge or the post-write check
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         readPulse_reg <= 1'b0;
         readCnt_reg <= 16'h0000;
      end else if (chanChange || memState_reg == MEM_CHECK) begin // [R10] [R13]
         readPulse_reg <= 1'b1;
         readCnt_reg <= 16'(READ_CYC - 1);
      end else if (readCnt_reg != 16'h0000) begin
         readCnt_reg <= readCnt_reg - 16'h0001;
      end else begin
         readPulse_reg <= 1'b0;
      end
   end
   assign readActive = readPulse_reg;

   // memory write from counter outputs; reset clears every channel so an unused one recalls zero,
   // not unknowns: the store is meant to be battery backed, so hold sys_rst only at power-up
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int c = 0; c < NUM_CHANNELS; c++) chanMem[c] <= 28'h0000000;
      end else if (writePulse) begin
         chanMem[chanIndex(sChan)] <= freqOut; // [R08] [R12]
      end
   end

   // decade counters: load, fast zeroing, stepping
   // preset word of the selected channel, shared by the load and its check
   logic [27:0] recallWord;
   assign recallWord = chanMem[chanIndex(sChan)]; // [R08]
   logic [27:0] freq_next;
   always_comb begin
      logic carry;
      logic [4:0] r;
      carry = 1'b0;
      r = 5'h00;
      freq_next = freqOut;
      if (readPulse_reg) begin
         freq_next = recallWord; // [R08] [R11]
      end else begin
         if (rate == RATE_FAST) freq_next[7:0] = 8'h00; // [R06]
         if (tuneClockGate && firstStageEnableGate) begin // [R01]
            carry = 1'b1;
            for (int i = 0; i < NUM_DIGITS; i++) begin
               if (carry && !(rate == RATE_FAST && i < 2)) begin // [R06]
                  r = digitStep(freq_next[i*4 +: 4], sUp, (i == NUM_DIGITS - 1) ? 4'(TOP_DIGIT_MAX) : 4'h9); // [R07]
                  freq_next[i*4 +: 4] = r[3:0];
                  carry = r[4];
               end
            end
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (sys_rst) freqOut <= 28'h0000000;
      else freqOut <= freq_next;
   end

   // panel outputs, registered
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         displayBlank <= 1'b0;
         wiperGround <= 1'b0;
         parallelLoadOut <= 1'b0;
      end else begin
         displayBlank <= ~dispOption2 & ~sTune; // [R14]
         wiperGround <= sPg_reg; // [R15]
         parallelLoadOut <= readPulse_reg; // [R11]
      end
   end

   // AXI4-Lite write channel: take address and data in any order
   logic awHeld_reg, wHeld_reg;
   logic [7:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         ctrl_reg <= CTRL_RESET;
      end else begin
         // readies kept as flops: each half closes when taken, both reopen with the response
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr[7:0];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            s_axi_wready <= 1'b0;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (awHeld_reg && wHeld_reg && !s_axi_bvalid) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awAddr_reg == CTRL_OFS) begin
               s_axi_bresp <= RESP_OKAY;
               for (int b = 0; b < 4; b++) if (wStrb_reg[b]) ctrl_reg[b*8 +: 8] <= wData_reg[b*8 +: 8];
            end else if (awAddr_reg == STATUS_OFS || awAddr_reg == FREQ_OFS) begin
               s_axi_bresp <= RESP_OKAY; // read-only, write ignored
            end else begin
               s_axi_bresp <= RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // AXI4-Lite read channel, one cycle latency
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
         s_axi_arready <= 1'b1;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_arready <= 1'b0; // one read in flight at a time
         s_axi_rresp <= RESP_OKAY;
         case (s_axi_araddr[7:0])
            CTRL_OFS: s_axi_rdata <= ctrl_reg;
            STATUS_OFS: s_axi_rdata <= {24'h000000, chanPrev_reg, tuneClockGate, displayBlank, writePulse, readPulse_reg};
            FREQ_OFS: s_axi_rdata <= {4'h0, freqOut};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // a channel change must yield a read pulse on the next cycle
   read_on_change_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R10]
      chanChange |=> readPulse_reg) else $error("no read after channel change");
   // prescaler frozen while loading; trips if the read term leaves the clock gate
   no_step_read_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R16]
      readPulse_reg |=> $stable(prescale_reg)) else $error("tune clock passed during read");
   sequence writeEnd_s;
      memState_reg == MEM_WRITE ##1 memState_reg == MEM_CHECK;
   endsequence
   check_read_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R13]
      writeEnd_s |=> readPulse_reg) else $error("no check read after write");
   top_digit_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R07]
      freqOut[27:24] <= 4'h2) else $error("top digit out of range");
   fast_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R06]
      (rate == RATE_FAST && !readPulse_reg) |=> freqOut[7:0] == 8'h00) else $error("low digits not zero");
   // the first cycle after reset still shows the reset value, so it is skipped
   wiper_pg_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R15]
      !$past(sys_rst) |-> wiperGround == $past(sPg_reg)) else $error("wiper not tracking power");
   blank_opt_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R14]
      (dispOption2 && $past(dispOption2)) |-> !displayBlank) else $error("blanked with option two");
   slow_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R04]
      (rate == RATE_SLOW && tuneClockGate && stageCountEnable_n && !readPulse_reg && freqOut[7:0] != 8'h00 && sUp)
      |=> freqOut[3:0] == $past(freqOut[3:0])) else $error("slow rate stepped early");
   // medium rate: every gated clock moves the 10 Hz digit by one
   medium_step_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R02] [R05]
      (rate == RATE_MEDIUM && tuneClockGate && sUp && freqOut[3:0] != 4'h9)
      |=> freqOut[3:0] == $past(freqOut[3:0]) + 4'h1) else $error("medium step missed");
   load_value_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R11]
      (readPulse_reg && !chanChange && !writePulse) |=> freqOut == $past(recallWord))
      else $error("parallel load value wrong");
endmodule : tuning_counter_channel_memory
`default_nettype wire

// ---- pulse_source_model.sv ----
// pulse_source_model: encoder pulse shaper and channel switch decoder ahead of the block
// assumes the bench calls step() from one process and moves chanNum at rising edges
`default_nettype none
module pulse_source_model (
   input wire logic core_clk,
   input wire logic [3:0] chanNum,
   output var tuning_pkg::tune_in_t tuneIn,
   output var tuning_pkg::chan_sel_t chanSel
);
   timeunit 1ns;
   timeprecision 1ps;
   import tuning_pkg::*;

   initial tuneIn = '0;

   // decoder splits the channel number into row select and two address lines
   always_comb chanSel = {chanNum[1], chanNum[0], chanNum[3:2]};

   // one knob detent: direction settles first so it is stable at every clock rise
   task automatic step(input logic up);
      logic [1:0] pat [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
      @(posedge core_clk);
      tuneIn <= {2'b00, up}; // direction line
      for (int i = 0; i < 4; i++) begin
         repeat (4) @(posedge core_clk);
         tuneIn <= {pat[i], up}; // doubled stream rises twice per detent
      end
      repeat (4) @(posedge core_clk);
   endtask : step
endmodule : pulse_source_model
`default_nettype wire

// ---- tb.sv ----
// tb: self-checking bench for the tuning counter with channel store
// assumes pulse_source_model drives encoder and switch lines; short one-shots
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tuning_pkg::*;
   localparam int RC = 4;
   localparam int WC = 8;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic tuneMode = 1'b1, loadKey = 1'b0, clarLimit = 1'b0, powerGood = 1'b1, up;
   logic [3:0] chanNum = 4'h0;
   logic [3:0] wstrb = 4'hF;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdat, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, displayBlank, wiperGround, parallelLoadOut;
   logic [1:0] bresp, rresp, rsp;
   logic [27:0] freqOut;
   tune_in_t tuneIn;
   chan_sel_t chanSel;
   int errTotal = 0, cmpCount = 0, freq = 0, n, saved;

   // free-running core clock, 50 ns period
   always #25 core_clk = ~core_clk;

   pulse_source_model knob (.core_clk(core_clk), .chanNum(chanNum), .tuneIn(tuneIn), .chanSel(chanSel));

   tuning_counter_channel_memory #(.READ_CYC(RC), .WRITE_CYC(WC)) uut (
      .core_clk(core_clk), .sys_rst(sys_rst), .tuneIn(tuneIn), .chanSel(chanSel),
      .tuneMode(tuneMode), .loadKey(loadKey), .clarLimit(clarLimit), .powerGood(powerGood),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .freqOut(freqOut), .displayBlank(displayBlank), .wiperGround(wiperGround),
      .parallelLoadOut(parallelLoadOut));

   // model value in 10 Hz units, seven digits with the top one limited to 0..2
   function automatic logic [27:0] bcd(input int f);
      logic [27:0] b;
      for (int i = 0; i < 7; i++) begin
         b[i*4 +: 4] = 4'(f % 10);
         f = f / 10;
      end
      return b;
   endfunction : bcd

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errTotal++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic tick(input int c);
      repeat (c) @(posedge core_clk);
   endtask : tick

   // handshake results are captured before the edge that takes them
   task automatic axiW(input logic [31:0] a, input logic [31:0] d);
      logic awT, wT, bT;
      bT = 1'b0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bT) begin
         @(negedge core_clk);
         awT = awvalid && (awready === 1'b1);
         wT = wvalid && (wready === 1'b1);
         bT = (bvalid === 1'b1);
         @(posedge core_clk);
         if (awT) awvalid <= 1'b0;
         if (wT) wvalid <= 1'b0;
         if (bT) bready <= 1'b0;
      end
   endtask : axiW

   task automatic axiR(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      logic arT, rT;
      rT = 1'b0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rT) begin
         @(negedge core_clk);
         arT = arvalid && (arready === 1'b1);
         rT = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         @(posedge core_clk);
         if (arT) arvalid <= 1'b0;
         if (rT) rready <= 1'b0;
      end
   endtask : axiR

   // one detent, then the counters against the model once the syncs have settled
   task automatic turn(input logic u, input int delta);
      knob.step(u);
      freq = (freq + delta + 3000000) % 3000000;
      tick(4);
      @(negedge core_clk);
      chk("freqOut", 32'(freqOut), 32'(bcd(freq)));
   endtask : turn

   task automatic endOfTest();
      $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
      if (errTotal == 0 && cmpCount > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : endOfTest

   // watchdog sized well above the roughly one thousand cycles the sequence needs
   initial begin
      repeat (20000) @(posedge core_clk);
      errTotal++;
      endOfTest();
   end

   initial begin
      void'($urandom(74217));
      tick(3);
      sys_rst <= 1'b0;
      tick(2);
      axiR(32'h0, rdat, rsp);
      chk("ctrlReset", rdat, CTRL_RESET);
      axiR(32'h10, rdat, rsp);
      chk("unmappedResp", 32'(rsp), 32'(RESP_SLVERR));
      @(negedge core_clk);
      chk("wiperOn", 32'(wiperGround), 32'h1);
      // slow rate: only every tenth gated clock reaches the first digit
      for (int i = 1; i <= 20; i++) turn(1'b1, (i % 10 == 0) ? 1 : 0);
      axiW(32'h0, 32'h1);
      turn(1'b1, 2); // two counts per detent
      // channel mode: clarifier past its limit stops the clocks
      @(posedge core_clk);
      tuneMode <= 1'b0;
      clarLimit <= 1'b1;
      turn(1'b1, 0);
      chk("blankOpt1", 32'(displayBlank), 32'h1);
      @(posedge core_clk);
      clarLimit <= 1'b0;
      turn(1'b0, -2);
      axiW(32'h0, 32'h5);
      tick(3);
      @(negedge core_clk);
      chk("blankOpt2", 32'(displayBlank), 32'h0);
      @(posedge core_clk);
      tuneMode <= 1'b1;
      n = $urandom_range(3, 6);
      repeat (n) begin
         up = 1'($urandom_range(0, 1));
         turn(up, up ? 2 : -2);
      end
      // fast rate: low digits cleared, 1 kHz steps, wrapping through the top digit
      axiW(32'h0, 32'h2);
      freq = freq / 100 * 100;
      tick(3);
      @(negedge core_clk);
      chk("fastClear", 32'(freqOut), 32'(bcd(freq)));
      repeat (2) turn(1'b0, -100);
      repeat (3) turn(1'b1, 100);
      axiR(32'h8, rdat, rsp);
      chk("freqReg", rdat, {4'h0, bcd(freq)});
      // store into channel 0, the check read must leave the value unchanged
      @(posedge core_clk);
      loadKey <= 1'b1;
      tick(6);
      loadKey <= 1'b0;
      tick(WC + RC + 12);
      @(negedge core_clk);
      chk("checkRead", 32'(freqOut), 32'(bcd(freq)));
      saved = freq;
      turn(1'b1, 100);
      @(posedge core_clk);
      chanNum <= 4'hB;
      tick(20);
      @(negedge core_clk);
      chk("recallEmpty", 32'(freqOut), 32'(bcd(0)));
      axiR(32'h4, rdat, rsp);
      chk("chanIndex", 32'(rdat[7:4]), 32'hB);
      @(posedge core_clk);
      chanNum <= 4'h0;
      n = 0;
      repeat (30) begin
         @(negedge core_clk);
         if (parallelLoadOut === 1'b1) n++;
      end
      chk("readPulse", 32'(n), 32'(RC));
      freq = saved;
      chk("recall", 32'(freqOut), 32'(bcd(freq)));
      // mains loss opens the wiper gate
      @(posedge core_clk);
      powerGood <= 1'b0;
      tick(5);
      @(negedge core_clk);
      chk("wiperOff", 32'(wiperGround), 32'h0);
      endOfTest();
   end
endmodule : tb
`default_nettype wire
